// ===== hw/cs_pkg.sv
// package: constants, tables and types of the clock synthesizer control block
package cs_pkg;

  // sampled sources, indices into the source vector
  localparam int SRC_CPU = 0;
  localparam int SRC_SDR = 1;
  localparam int SRC_PCI = 2;
  localparam int SRC_REF = 3;
  localparam int SRC_USB = 4;
  localparam int SRC_SIO = 5;
  localparam int N_SRC   = 6;

  // clock outputs, indices into the output vector
  localparam int CK_FREE_CPU  = 0;
  localparam int CK_GATED_CPU = 1;
  localparam int CK_FREE_PCI  = 2;
  localparam int CK_PCI0      = 3;
  localparam int CK_PCI4      = 7;
  localparam int CK_SDR0      = 8;
  localparam int CK_SDR12     = 20;
  localparam int CK_INTR_CTRL = 21;
  localparam int CK_REF_OUT   = 22;
  localparam int CK_REF_AUX   = 23;
  localparam int CK_USB48     = 24;
  localparam int CK_SIO24     = 25;
  localparam int N_CLK        = 26;

  // serial slave
  localparam logic [6:0] SLAVE_ADDR = 7'h69;
  localparam logic [3:0] BIT_LAST   = 4'h8;
  localparam int         N_REGS     = 6;
  localparam logic [2:0] PTR_MAX    = 3'h7;
  localparam logic [7:0] REG0_RESET = 8'h00;
  localparam logic [7:0] REGN_RESET = 8'hFF;

  // register 0 fields
  localparam int R0_TRISTATE = 0;
  localparam int R0_SS_EN    = 1;
  localparam int R0_SOFT_B3  = 2;
  localparam int R0_SW_SRC   = 3;
  localparam int R0_SOFT_LO  = 4;
  localparam int R0_SOFT_HI  = 6;
  localparam int R0_SS_HALF  = 7;
  // read-only strap copies in registers 1 and 4
  localparam int R1_FS2_INV  = 7;
  localparam int R4_FS1_INV  = 3;

  // strap capture delay after reset release, clk cycles
  localparam logic [3:0] STRAP_WAIT = 4'h4;

  // cpu frequency in 10 kHz units, entry 7 leftmost
  localparam logic [7:0][15:0] FREQ3 = {16'h2724, 16'h33F4, 16'h2BC0, 16'h283C,
                                        16'h1A18, 16'h208A, 16'h1D4C, 16'h1388};
  localparam logic [7:0][15:0] FREQ4L = {16'h272E, 16'h33F4, 16'h2BC0, 16'h283C,
                                         16'h1A18, 16'h208A, 16'h1D4C, 16'h3070};
  localparam logic [7:0][15:0] FREQ4H = {16'h33F4, 16'h3070, 16'h3A98, 16'h36B0,
                                         16'h2904, 16'h2AF8, 16'h2CEC, 16'h2EE0};
  // pci divisor of the cpu clock
  localparam logic [7:0][2:0] DIV3  = {3'h3, 3'h4, 3'h3, 3'h3, 3'h2, 3'h2, 3'h2, 3'h2};
  localparam logic [7:0][2:0] DIV4L = {3'h3, 3'h3, 3'h3, 3'h3, 3'h2, 3'h2, 3'h2, 3'h3};
  localparam logic [7:0][2:0] DIV4H = {3'h4, 3'h4, 3'h4, 3'h4, 3'h3, 3'h3, 3'h3, 3'h3};

  typedef struct packed {
    logic [15:0] cpu_10khz;
    logic [2:0]  pci_div;
    logic [3:0]  code;
    logic        ss_en;
    logic        ss_half;
  } cs_freq_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } cs_state_t;

  typedef enum logic [3:0] {
    PH_ADDR = 4'h1,
    PH_CMD  = 4'h2,
    PH_CNT  = 4'h4,
    PH_DATA = 4'h8
  } cs_phase_t;

endpackage

// ===== hw/cs_clk_gate.sv
// glitch-free run/stop gate for one sampled clock output
`timescale 1ns/1ps
module cs_clk_gate
  import cs_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic src,
  input  wire logic pci_rise,
  input  wire logic run,
  output logic      out_q
);

  logic src_d_q;
  logic arm_q;
  logic on_q;
  wire  src_fall = src_d_q & ~src;
  wire  arm_set  = (run != on_q) & pci_rise;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      src_d_q <= 1'b0;
      arm_q   <= 1'b0;
      on_q    <= 1'b0;
      out_q   <= 1'b0;
    end else begin
      src_d_q <= src;
      // state flips only on a falling edge, so no high phase is cut short
      if (arm_q && src_fall) begin
        on_q  <= run;
        arm_q <= 1'b0;
      end else if (arm_set) begin
        arm_q <= 1'b1;
      end
      out_q <= src & on_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_no_runt_pulse: assert property ($fell(out_q) |-> !$past(src))
    else $error("gated clock fell while its source was high");
  a_change_after_pci: assert property ($changed(on_q) |-> $past(arm_q) && $past(src_fall))
    else $error("gate changed without pci edge then falling edge");
  a_stopped_low: assert property (!on_q ##1 !on_q |-> !out_q)
    else $error("stopped clock not held low");

endmodule

// ===== hw/cs_clock_synth_control.sv
// top: strap latch, stop-pin and enable gating, frequency decode and serial control slave
`timescale 1ns/1ps

// Summary of operation
// - three-select variant: eight-entry frequency table
// - four-select variant: fourth bit picks table
// - latched mode: 0 stop input, 1 reference out
// - each clock output has a register enable
// - stop pins work only in mode 0
// - clock runs when enable set and stop pin high
// - stopped clocks low, no runt pulse
// - change after pci rise, then own fall
// - cpu stop and pci stop clock groups
// - registers can be read back by master
// - power-up defaults work without serial access
// - start, stop, bytes with acknowledge
// - acknowledge own address and each later received byte by pulling low
// - command and count ignored, data sequential
// - register 0 spread enable and depth
// - register 0 bit 3 picks select source
// - software code uses the strap table
// - register 0 bit 0 tristates all clock outputs
// - register 0 resets to zero
// - frequency straps latched only at power-up
// - disabled output held low
module cs_clock_synth_control
  import cs_pkg::*;
#(
  parameter bit FOUR_SEL = 1'b1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [N_SRC-1:0] src_clk,
  input  wire logic             cpu_stop_n,
  input  wire logic             pci_stop_n,
  input  wire logic             mode_strap,
  input  wire logic             freq_strap_bit0,
  input  wire logic             freq_strap_bit1,
  input  wire logic             freq_strap_bit2,
  input  wire logic             freq_strap_bit3,
  input  wire logic             serial_clock_line,
  input  wire logic             serial_data_line_in,
  output logic                  serial_data_line_out,
  output logic                  serial_data_line_oe_n,
  output logic [N_CLK-1:0]      clk_out,
  output logic [N_CLK-1:0]      clk_oe_n,
  output cs_freq_t              freq_q
);

  localparam int N_PIN = N_SRC + 9;

  // two-stage synchronisers for every pin input
  logic [N_PIN-1:0] sync1_q;
  logic [N_PIN-1:0] sync2_q;
  wire  [N_PIN-1:0] pin_in = {serial_clock_line, serial_data_line_in, cpu_stop_n, pci_stop_n, mode_strap,
                              freq_strap_bit3, freq_strap_bit2, freq_strap_bit1, freq_strap_bit0, src_clk};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  wire [N_SRC-1:0] src_s      = sync2_q[N_SRC-1:0];
  wire [3:0]       fs_s       = sync2_q[N_SRC+3:N_SRC];
  wire             mode_s     = sync2_q[N_SRC+4];
  wire             pci_stop_s = sync2_q[N_SRC+5];
  wire             cpu_stop_s = sync2_q[N_SRC+6];
  wire             sda_s      = sync2_q[N_SRC+7];
  wire             scl_s      = sync2_q[N_SRC+8];

  // strap latch, once after reset release
  logic [3:0] wait_q;
  logic       strap_done_q;
  logic       mode_q;
  logic [3:0] fs_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_q       <= 4'h0;
      strap_done_q <= 1'b0;
      mode_q       <= 1'b0;
      fs_q         <= 4'h0;
    end else if (!strap_done_q) begin
      if (wait_q == STRAP_WAIT) begin
        strap_done_q <= 1'b1;
        mode_q       <= mode_s;
        fs_q         <= fs_s;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end

  // serial slave state
  cs_state_t  st_q, st_d;
  cs_phase_t  phase_q, phase_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d;
  logic [2:0] ptr_q, ptr_d;
  logic       rd_q, rd_d;
  logic       nack_q, nack_d;
  logic       sda_oe_d;
  logic       wr_en;
  logic       scl_d_q;
  logic       sda_d_q;
  logic [7:0] regs_q [N_REGS];

  wire scl_rise   = scl_s & ~scl_d_q;
  wire scl_fall   = ~scl_s & scl_d_q;
  wire start_cond = scl_s & scl_d_q & sda_d_q & ~sda_s;
  wire stop_cond  = scl_s & scl_d_q & ~sda_d_q & sda_s;
  wire addr_hit   = shift_q[7:1] == SLAVE_ADDR;
  wire byte_done  = scl_fall && (bit_q == BIT_LAST);
  wire [2:0] ptr_inc = (ptr_q == PTR_MAX) ? ptr_q : ptr_q + 3'h1;

  wire [7:0] r0 = regs_q[0];
  wire [7:0] r1 = regs_q[1];
  wire [7:0] r2 = regs_q[2];
  wire [7:0] r3 = regs_q[3];
  wire [7:0] r5 = regs_q[5];

  // read-back byte with the inverted strap copies in place
  wire [7:0] rd_r1   = {~fs_q[2], r1[R1_FS2_INV-1:0]};
  wire [7:0] rd_r4   = {regs_q[4][7:R4_FS1_INV+1], ~fs_q[1], regs_q[4][R4_FS1_INV-1:0]};
  wire       ptr_ok  = ptr_q < 3'(N_REGS);
  wire [7:0] rd_raw  = ptr_ok ? regs_q[ptr_q] : 8'h00;
  wire [7:0] rd_byte = (ptr_q == 3'h1) ? rd_r1 : (ptr_q == 3'h4) ? rd_r4 : rd_raw;

  always_comb begin
    st_d     = st_q;
    phase_d  = phase_q;
    bit_d    = bit_q;
    shift_d  = shift_q;
    ptr_d    = ptr_q;
    rd_d     = rd_q;
    nack_d   = nack_q;
    sda_oe_d = serial_data_line_oe_n;
    wr_en    = 1'b0;
    if (start_cond) begin
      st_d     = ST_RX;
      phase_d  = PH_ADDR;
      bit_d    = 4'h0;
      ptr_d    = 3'h0;
      rd_d     = 1'b0;
      sda_oe_d = 1'b1;
    end else if (stop_cond) begin
      st_d     = ST_IDLE;
      sda_oe_d = 1'b1;
    end else if (scl_rise) begin
      case (st_q)
        ST_RX: begin
          shift_d = {shift_q[6:0], sda_s};
          bit_d   = bit_q + 4'h1;
        end
        ST_TX:   bit_d  = bit_q + 4'h1;
        ST_MACK: nack_d = sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st_q)
        ST_RX: begin
          if (bit_q == BIT_LAST) begin
            bit_d = 4'h0;
            if (phase_q == PH_ADDR && !addr_hit) begin
              st_d = ST_IDLE;
            end else begin
              st_d     = ST_ACK;
              sda_oe_d = 1'b0;
              if (phase_q == PH_ADDR) rd_d = shift_q[0];
              if (phase_q == PH_DATA) begin
                wr_en = ptr_ok;
                ptr_d = ptr_inc;
              end
            end
          end
        end
        ST_ACK: begin
          if (rd_q) begin
            st_d     = ST_TX;
            sda_oe_d = rd_byte[7];
            shift_d  = {rd_byte[6:0], 1'b0};
          end else begin
            st_d     = ST_RX;
            sda_oe_d = 1'b1;
            case (phase_q)
              PH_ADDR: phase_d = PH_CMD;
              PH_CMD:  phase_d = PH_CNT;
              default: phase_d = PH_DATA;
            endcase
          end
        end
        ST_TX: begin
          if (bit_q == BIT_LAST) begin
            st_d     = ST_MACK;
            sda_oe_d = 1'b1;
            ptr_d    = ptr_inc;
          end else begin
            sda_oe_d = shift_q[7];
            shift_d  = {shift_q[6:0], 1'b0};
          end
        end
        ST_MACK: begin
          bit_d = 4'h0;
          if (nack_q) begin
            st_d = ST_IDLE;
          end else begin
            st_d     = ST_TX;
            sda_oe_d = rd_byte[7];
            shift_d  = {rd_byte[6:0], 1'b0};
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q                  <= ST_IDLE;
      phase_q               <= PH_ADDR;
      bit_q                 <= 4'h0;
      shift_q               <= 8'h00;
      ptr_q                 <= 3'h0;
      rd_q                  <= 1'b0;
      nack_q                <= 1'b0;
      scl_d_q               <= 1'b0;
      sda_d_q               <= 1'b0;
      serial_data_line_oe_n <= 1'b1;
      serial_data_line_out  <= 1'b0;
    end else begin
      st_q                  <= st_d;
      phase_q               <= phase_d;
      bit_q                 <= bit_d;
      shift_q               <= shift_d;
      ptr_q                 <= ptr_d;
      rd_q                  <= rd_d;
      nack_q                <= nack_d;
      scl_d_q               <= scl_s;
      sda_d_q               <= sda_s;
      serial_data_line_oe_n <= sda_oe_d;
      serial_data_line_out  <= 1'b0;
    end
  end

  // control registers, usable from reset with no serial access
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regs_q[0] <= REG0_RESET;
      for (int i = 1; i < N_REGS; i++) begin
        regs_q[i] <= REGN_RESET;
      end
    end else if (wr_en) begin
      regs_q[ptr_q] <= shift_q;
    end
  end

  // frequency decode; software code uses the same tables as the straps
  wire [3:0] code_sel = r0[R0_SW_SRC] ? {r0[R0_SOFT_B3], r0[R0_SOFT_HI:R0_SOFT_LO]} : fs_q;
  wire [2:0] idx      = code_sel[2:0];
  wire [15:0] f4      = code_sel[3] ? FREQ4H[idx] : FREQ4L[idx];
  wire [2:0]  d4      = code_sel[3] ? DIV4H[idx] : DIV4L[idx];
  wire [15:0] f_sel   = FOUR_SEL ? f4 : FREQ3[idx];
  wire [2:0]  d_sel   = FOUR_SEL ? d4 : DIV3[idx];
  wire [3:0]  code_o  = FOUR_SEL ? code_sel : {1'b0, idx};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      freq_q <= '0;
    end else begin
      freq_q.cpu_10khz <= f_sel;
      freq_q.pci_div   <= d_sel;
      freq_q.code      <= code_o;
      freq_q.ss_en     <= r0[R0_SS_EN];
      freq_q.ss_half   <= r0[R0_SS_HALF];
    end
  end

  // per-output enables from the serial registers
  wire [N_CLK-1:0] en_vec = {r3[4], r3[5], r5[1], r5[0], r5[4], r1[3], {4{r3[2]}}, {4{r3[1]}},
                             {4{r3[0]}}, r2[4:0], r2[6], r1[1], r1[0]};

  // stop pins count only in mode 0
  wire cpu_run = mode_q | cpu_stop_s;
  wire pci_run = mode_q | pci_stop_s;
  wire [N_CLK-1:0] stop_vec = {4'hF, {14{cpu_run}}, {5{pci_run}}, 1'b1, cpu_run, 1'b1};
  wire [N_CLK-1:0] run_vec  = en_vec & stop_vec;

  wire [N_CLK-1:0] src_vec = {src_s[SRC_SIO], src_s[SRC_USB], src_s[SRC_REF], src_s[SRC_REF], src_s[SRC_REF],
                              {13{src_s[SRC_SDR]}}, {6{src_s[SRC_PCI]}}, src_s[SRC_CPU], src_s[SRC_CPU]};

  logic pci_d_q;
  wire  pci_rise = src_s[SRC_PCI] & ~pci_d_q;

  // shared strap pins stay released until capture; the stop-input pin stays released in mode 0
  wire [N_CLK-1:0] strap_pins = N_CLK'((1 << CK_FREE_PCI) | (1 << CK_PCI0) | (1 << CK_REF_AUX) |
                                       (1 << CK_USB48) | (1 << CK_SIO24));
  wire [N_CLK-1:0] ref_in     = N_CLK'(1 << CK_REF_OUT);
  wire [N_CLK-1:0] oe_n_d     = {N_CLK{r0[R0_TRISTATE]}} | (strap_done_q ? '0 : (strap_pins | ref_in)) |
                                (mode_q ? '0 : ref_in);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pci_d_q  <= 1'b0;
      clk_oe_n <= '1;
    end else begin
      pci_d_q  <= src_s[SRC_PCI];
      clk_oe_n <= oe_n_d;
    end
  end

  for (genvar g = 0; g < N_CLK; g++) begin : g_gate
    cs_clk_gate u_gate (
      .clk      (clk),
      .reset    (reset),
      .src      (src_vec[g]),
      .pci_rise (pci_rise),
      .run      (run_vec[g]),
      .out_q    (clk_out[g])
    );
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_ref_pin_input: assert property (strap_done_q && !mode_q |=> clk_oe_n[CK_REF_OUT])
    else $error("reference pin driven while it is the stop input");
  a_stop_ignored: assert property (mode_q |-> run_vec == en_vec)
    else $error("stop pin acted in mode 1");
  a_run_needs_both: assert property (run_vec[CK_GATED_CPU] == (en_vec[CK_GATED_CPU] && cpu_run))
    else $error("gated cpu run request wrong");
  a_cpu_stop_group: assert property (!mode_q && !cpu_stop_s |-> run_vec[CK_INTR_CTRL:CK_SDR0] == '0 &&
                                     !run_vec[CK_GATED_CPU] && run_vec[CK_FREE_CPU] == en_vec[CK_FREE_CPU])
    else $error("cpu stop group not stopped");
  a_pci_stop_group: assert property (!mode_q && !pci_stop_s |-> run_vec[CK_PCI4:CK_PCI0] == '0 &&
                                     run_vec[CK_FREE_PCI] == en_vec[CK_FREE_PCI])
    else $error("pci stop group not stopped");
  a_addr_ack: assert property (st_q == ST_RX && phase_q == PH_ADDR && byte_done && addr_hit
                               |=> !serial_data_line_oe_n ##1 st_q == ST_ACK)
    else $error("own address not acknowledged");
  a_addr_miss: assert property (st_q == ST_RX && phase_q == PH_ADDR && byte_done && !addr_hit && !start_cond
                                |=> serial_data_line_oe_n && st_q == ST_IDLE)
    else $error("foreign address acknowledged");
  a_data_store: assert property (wr_en && ptr_q == 3'h0 |=> regs_q[0] == $past(shift_q) && ptr_q == 3'h1)
    else $error("first data byte not stored in register 0");
  a_read_first_bit: assert property (st_q == ST_ACK && rd_q && scl_fall && !start_cond && !stop_cond
                                     |=> serial_data_line_oe_n == $past(rd_byte[7]))
    else $error("read data bit wrong");
  a_soft_select: assert property (r0[R0_SW_SRC] && FOUR_SEL |=> freq_q.code == $past(code_sel) &&
                                  freq_q.code == {$past(r0[R0_SOFT_B3]), $past(r0[R0_SOFT_HI:R0_SOFT_LO])})
    else $error("software select not applied");
  a_tristate_all: assert property (r0[R0_TRISTATE] |=> &clk_oe_n)
    else $error("outputs not released in tristate mode");
  a_strap_once: assert property (strap_done_q |=> $stable(fs_q) && $stable(mode_q) && strap_done_q)
    else $error("strap latch changed after power-up");

  c_reg_write: cover property (wr_en);
  c_read_byte: cover property (st_q == ST_MACK && scl_rise && !sda_s);
  c_cpu_stopped: cover property ($fell(clk_out[CK_GATED_CPU]) ##[1:40] !run_vec[CK_GATED_CPU]);

endmodule

// ===== sim/cs_twi_master.sv
// two-wire bus master model standing in for the chipset side
`timescale 1ns/1ps
module cs_twi_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe_n
);
  // half period kept well above the slave's synchroniser and detect latency
  localparam int HALF = 12;

  initial begin
    scl      = 1'b1;
    sda_oe_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // data released while the clock is low, then pulled low with the clock high; works as a repeated start too
  task automatic start();
    tick(4);
    sda_oe_n = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_oe_n = 1'b0;
    tick(HALF);
    scl = 1'b0;
  endtask

  task automatic stop();
    tick(4);
    sda_oe_n = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_oe_n = 1'b1;
    tick(HALF);
  endtask

  task automatic bit_io(input logic d, output logic q);
    tick(4);
    sda_oe_n = d;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    q   = sda;
    scl = 1'b0;
  endtask

  // eight bits msb first, then a ninth bit driven with last
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], q);
      rx[i] = q;
    end
    bit_io(last, q);
    ack = ~q;
  endtask
endmodule

// ===== sim/test_clock_synth_control.sv
// bench: strap latch, serial register access and clock gating of the synthesizer control
`timescale 1ns/1ps
module test_clock_synth_control;
  import cs_pkg::*;
  logic             clk;
  logic             reset;
  logic             link_ck;
  logic             cpu_stop_n;
  logic             pci_stop_n;
  logic             mode_strap;
  logic [3:0]       fs;
  logic             scl;
  logic             m_oe_n;
  logic             sda_out;
  logic             sda_oe_n;
  wire              sda_wire;
  logic [N_CLK-1:0] clk_out;
  logic [N_CLK-1:0] clk_oe_n;
  cs_freq_t         freq_q;
  int               failures;
  int               compares;

  // pull-up on the data wire: either party pulls it low
  assign sda_wire = m_oe_n & sda_oe_n;

  initial clk = 1'b0;
  always #5 clk = ~clk;
  initial link_ck = 1'b0;
  always #62.5 link_ck = ~link_ck;

  cs_clock_synth_control u_cs_clock_synth_control (
    .clk                   (clk),
    .reset                 (reset),
    .src_clk               ({N_SRC{link_ck}}),
    .cpu_stop_n            (cpu_stop_n),
    .pci_stop_n            (pci_stop_n),
    .mode_strap            (mode_strap),
    .freq_strap_bit0       (fs[0]),
    .freq_strap_bit1       (fs[1]),
    .freq_strap_bit2       (fs[2]),
    .freq_strap_bit3       (fs[3]),
    .serial_clock_line     (scl),
    .serial_data_line_in   (sda_wire),
    .serial_data_line_out  (sda_out),
    .serial_data_line_oe_n (sda_oe_n),
    .clk_out               (clk_out),
    .clk_oe_n              (clk_oe_n),
    .freq_q                (freq_q)
  );

  cs_twi_master u_cs_twi_master (
    .clk      (clk),
    .sda      (sda_wire),
    .scl      (scl),
    .sda_oe_n (m_oe_n)
  );

  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic put(input logic [7:0] b, input logic exp_ack);
    logic [7:0] rx;
    logic       ack;
    u_cs_twi_master.xfer(b, 1'b1, rx, ack);
    check("ack", {15'h0, exp_ack}, {15'h0, ack});
  endtask

  // header bytes always go out, since registers are only reached in order
  task automatic wr(input logic [7:0] r0, input logic [7:0] r1, input logic two);
    u_cs_twi_master.start();
    put(8'hD2, 1'b1);
    put(8'hA5, 1'b1);
    put(8'h3C, 1'b1);
    put(r0, 1'b1);
    if (two) put(r1, 1'b1);
    u_cs_twi_master.stop();
    repeat (10) @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] exp [6]);
    logic [7:0] rx;
    logic       ack;
    u_cs_twi_master.start();
    put(8'hD3, 1'b1);
    for (int i = 0; i < 6; i++) begin
      u_cs_twi_master.xfer(8'hFF, i == 5, rx, ack);
      check("readback", {8'h0, exp[i]}, {8'h0, rx});
    end
    u_cs_twi_master.stop();
  endtask

  // first 40 cycles leave room for the pci-edge then own-fall handover
  task automatic watch(input int idx, input logic runs);
    logic saw;
    int   hi;
    int   runt;
    saw  = 1'b0;
    hi   = 5;
    runt = 0;
    for (int i = 0; i < 120; i++) begin
      @(negedge clk);
      if (clk_out[idx] === 1'b1) begin
        hi++;
      end else begin
        if (hi > 0 && hi < 5) runt = 1;
        hi = 0;
      end
      if (i >= 40) saw = saw | clk_out[idx];
    end
    check("clock runs", {15'h0, runs}, {15'h0, saw});
    check("short high", 16'h0, runt[15:0]);
  endtask

  task automatic stops(input logic c, input logic p);
    cpu_stop_n = c;
    pci_stop_n = p;
    watch(CK_GATED_CPU, c);
    watch(CK_SDR12, c);
    watch(CK_INTR_CTRL, c);
    watch(CK_PCI4, p);
    watch(CK_FREE_CPU, 1'b1);
    watch(CK_FREE_PCI, 1'b1);
  endtask

  task automatic do_reset(input logic m);
    reset      = 1'b1;
    mode_strap = m;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    // sources are ideal here, so the host settling wait shrinks to a few cycles
    repeat (20) @(negedge clk);
  endtask

  initial begin
    #500us;
    failures++;
    close_out();
  end

  initial begin
    failures   = 0;
    compares   = 0;
    cpu_stop_n = 1'b1;
    pci_stop_n = 1'b1;
    fs         = 4'hD;
    do_reset(1'b0);
    check("cpu freq", 16'h3A98, freq_q.cpu_10khz);
    check("pci div", 16'h4, {13'h0, freq_q.pci_div});
    check("ref oe", 16'h1, {15'h0, clk_oe_n[CK_REF_OUT]});
    fs = 4'h0;
    repeat (20) @(negedge clk);
    check("cpu freq", 16'h3A98, freq_q.cpu_10khz);
    // straps copied inverted into registers 1 and 4
    rd('{8'h00, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
    u_cs_twi_master.start();
    put(8'hD4, 1'b0);
    u_cs_twi_master.stop();
    wr(8'hEA, 8'hFD, 1'b1);
    check("cpu freq", 16'h33F4, freq_q.cpu_10khz);
    check("pci div", 16'h3, {13'h0, freq_q.pci_div});
    check("spread", 16'h3, {14'h0, freq_q.ss_en, freq_q.ss_half});
    check("code", 16'h6, {12'h0, freq_q.code});
    rd('{8'hEA, 8'h7D, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
    check("data out", 16'h0, {15'h0, sda_out});
    watch(CK_GATED_CPU, 1'b0);
    watch(CK_FREE_CPU, 1'b1);
    wr(8'hEA, 8'hFF, 1'b1);
    for (int k = 0; k < 4; k++) stops(k[1], k[0]);
    stops(1'b1, 1'b1);
    wr(8'h01, 8'h00, 1'b0);
    check("tristate", 16'h0, {3'h0, ~clk_oe_n[12:0]});
    check("tristate hi", 16'h0, {3'h0, ~clk_oe_n[N_CLK-1:13]});
    wr(8'h00, 8'h00, 1'b0);
    check("oe cpu", 16'h0, {15'h0, clk_oe_n[CK_FREE_CPU]});
    do_reset(1'b1);
    check("ref oe", 16'h0, {15'h0, clk_oe_n[CK_REF_OUT]});
    cpu_stop_n = 1'b0;
    pci_stop_n = 1'b0;
    watch(CK_GATED_CPU, 1'b1);
    watch(CK_PCI0, 1'b1);
    close_out();
  end
endmodule
